// ==== src/rmcb_cfg.svh ====
// Offsets, field positions, reset values and counts of the receiver control bits.
// Assumes inclusion by the package, the design file and the bench.
`ifndef RMCB_CFG_SVH
`define RMCB_CFG_SVH
`define RMCB_OFF_CSR 12'h000
`define RMCB_OFF_DBUF 12'h004
`define RMCB_OFF_ISTAT 12'h008
`define RMCB_OFF_IMASK 12'h00c
`define RMCB_OFF_SYNC 12'h010
`define RMCB_BIT_CHG_B 0
`define RMCB_BIT_DTR 1
`define RMCB_BIT_RTS 2
`define RMCB_BIT_SEC_TX 3
`define RMCB_BIT_RCV_EN 4
`define RMCB_BIT_CHG_IEN 5
`define RMCB_BIT_RX_IEN 6
`define RMCB_BIT_DONE 7
`define RMCB_BIT_ACTIVE 11
`define RMCB_BIT_CHG_A 15
`define RMCB_IRQ_CHG_B 0
`define RMCB_IRQ_CHG_A 1
`define RMCB_IRQ_DONE 2
`define RMCB_IRQ_W 3
`define RMCB_SYNC_RESET 8'h96
`define RMCB_LAST_BIT 3'h7
`endif

// ==== src/rmcb_pkg.sv ====
// Types shared by the receiver control bits design.
// Assumes rmcb_cfg.svh is on the include path.
`include "rmcb_cfg.svh"
package rmcb_pkg;
	typedef enum logic [1:0] {RX_IDLE, RX_HUNT, RX_ACTIVE} rmcb_rx_state_t;
	typedef logic [`RMCB_IRQ_W-1:0] rmcb_irq_t;
endpackage : rmcb_pkg

// ==== src/rmcb_receiver_control.sv ====
// Receiver control and status bits with modem leads, sync hunt and APB slave.
// Assumes pclk at 40 MHz; modem leads and the modem clock are asynchronous.
`timescale 1ns/10ps
`default_nettype none
`include "rmcb_cfg.svh"

// What this block does
// R1: Setting enable starts hunting for sync.
// R2: Data accepted only while enable stays set.
// R3: Clearing enable resets receiver at once.
// R4: Enable falling clears the character-done flag.
// R5: Enable is read/write, cleared by resets.
// R6: Bit 3 drives secondary transmit line.
// R7: Modem bits read/write; init clearing optional.
// R8: Bit 2 drives request to send.
// R9: Bit 1 drives data terminal ready.
// R10: Modem line transitions set change B.
// R11: Jumper option inhibits change B.
// R12: Option routes transitions to change A.
// R13: Change B read-only, cleared by read.
// R14: Character transfer sets character-done flag.
// R15: Change A with enable requests interrupt.
// R16: Modem inputs synchronised, edges counted once.
module rmcb_receiver_control import rmcb_pkg::*; #(
	parameter bit INIT_CLEARS_MODEM = 1'b1,
	parameter bit CHANGE_JUMPER_FITTED = 1'b1,
	parameter bit CHANGE_ROUTE_TO_A = 1'b0
) (
	input wire logic pclk, // system clock
	input wire logic presetn, // device reset, async, active low
	input wire logic [11:0] paddr, // byte address
	input wire logic psel, // slave select
	input wire logic penable, // access phase
	input wire logic pwrite, // write direction
	input wire logic [31:0] pwdata, // write data
	output logic [31:0] prdata, // read data
	output logic pready, // transfer done
	output logic pslverr, // unmapped address
	input wire logic bus_init, // bus initialize pulse, pclk domain
	input wire logic change_a_event, // other change A source, pclk domain
	input wire logic modem_clock, // receive clock from the modem
	input wire logic modem_rx_data, // received serial data
	input wire logic carrier, // carrier detect lead
	input wire logic data_set_ready, // data set ready lead
	input wire logic sec_rx_data, // secondary received data lead
	output logic sec_tx_data, // secondary transmit lead
	output logic request_to_send, // request to send lead
	output logic data_terminal_ready, // data terminal ready lead
	output logic rx_vector_req, // receiver vector interrupt request
	output logic irq // masked sticky status interrupt
);

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	logic [4:0] sync1;
	logic [4:0] sync2;
	logic [4:0] sync3;
	logic [2:0] settle;
	wire [4:0] raw_in = {sec_rx_data, data_set_ready, carrier, modem_rx_data, modem_clock};

	// R16 two-flop synchronise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= 5'h00;
			sync2 <= 5'h00;
			sync3 <= 5'h00;
			settle <= 3'h0;
		end else begin
			sync1 <= raw_in;
			sync2 <= sync1;
			sync3 <= sync2;
			settle <= {settle[1:0], 1'b1};
		end
	end

	// R16 one edge per transition
	// Edges wait until sync3 holds a real sample, so a lead already high at reset is no change.
	wire settled = settle[2];
	wire line_change = settled & |(sync2[4:2] ^ sync3[4:2]);
	wire clk_rise = settled & sync2[0] & ~sync3[0];
	wire rx_bit = sync2[1];

	// ************************************************************
	// APB decode
	// ************************************************************
	wire setup = psel & ~penable;
	wire access = psel & penable;
	wire sel_csr = paddr == `RMCB_OFF_CSR;
	wire sel_dbuf = paddr == `RMCB_OFF_DBUF;
	wire sel_istat = paddr == `RMCB_OFF_ISTAT;
	wire sel_imask = paddr == `RMCB_OFF_IMASK;
	wire sel_sync = paddr == `RMCB_OFF_SYNC;
	wire mapped = sel_csr | sel_dbuf | sel_istat | sel_imask | sel_sync;
	wire wr = access & pwrite & mapped;
	wire rd = access & ~pwrite & mapped;
	wire wr_csr = wr & sel_csr;
	wire rd_csr = rd & sel_csr;
	wire rd_dbuf = rd & sel_dbuf;

	assign pready = access;
	assign pslverr = access & ~mapped;

	// ************************************************************
	// Control bits
	// ************************************************************
	logic receiver_enable;
	logic en_prev;
	logic chg_irq_en;
	logic rx_irq_en;
	logic [7:0] sync_pattern;
	rmcb_irq_t irq_mask;

	// R5 enable read/write, cleared by init
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			receiver_enable <= 1'b0;
			chg_irq_en <= 1'b0;
			rx_irq_en <= 1'b0;
		end else if (bus_init) begin
			receiver_enable <= 1'b0;
			chg_irq_en <= 1'b0;
			rx_irq_en <= 1'b0;
		end else if (wr_csr) begin
			receiver_enable <= pwdata[`RMCB_BIT_RCV_EN];
			chg_irq_en <= pwdata[`RMCB_BIT_CHG_IEN];
			rx_irq_en <= pwdata[`RMCB_BIT_RX_IEN];
		end
	end

	// Modem leads follow their bits with no further logic, so software owns timing.
	// R7 optional clear on init
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sec_tx_data <= 1'b0;
			request_to_send <= 1'b0;
			data_terminal_ready <= 1'b0;
		end else if (bus_init && INIT_CLEARS_MODEM) begin
			sec_tx_data <= 1'b0;
			request_to_send <= 1'b0;
			data_terminal_ready <= 1'b0;
		end else if (wr_csr) begin
			// R6 secondary transmit bit
			sec_tx_data <= pwdata[`RMCB_BIT_SEC_TX];
			// R8 request to send
			request_to_send <= pwdata[`RMCB_BIT_RTS];
			// R9 data terminal ready
			data_terminal_ready <= pwdata[`RMCB_BIT_DTR];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_pattern <= `RMCB_SYNC_RESET;
			irq_mask <= '0;
			en_prev <= 1'b0;
		end else begin
			en_prev <= receiver_enable;
			if (wr && sel_sync) begin
				sync_pattern <= pwdata[7:0];
			end
			if (wr && sel_imask) begin
				irq_mask <= pwdata[`RMCB_IRQ_W-1:0];
			end
		end
	end

	// ************************************************************
	// Receiver timing and sync hunt
	// ************************************************************
	rmcb_rx_state_t state;
	logic [7:0] shift;
	logic [2:0] bit_count;
	logic [7:0] rx_data_buffer;
	logic rx_char_done;
	wire [7:0] next_shift = {shift[6:0], rx_bit};
	wire rx_active = state == RX_ACTIVE;
	// R14 transfer into data buffer
	wire char_load = rx_active & receiver_enable & clk_rise & (bit_count == `RMCB_LAST_BIT);
	wire enable_fell = en_prev & ~receiver_enable;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= RX_IDLE;
			shift <= 8'h00;
			bit_count <= 3'h0;
		end else if (!receiver_enable) begin
			// R3 immediate receiver reset
			state <= RX_IDLE;
			shift <= 8'h00;
			bit_count <= 3'h0;
		end else begin
			case (state)
				RX_IDLE: begin
					// R1 start hunting
					state <= RX_HUNT;
				end
				RX_HUNT: begin
					if (clk_rise) begin
						shift <= next_shift;
						if (next_shift == sync_pattern) begin
							state <= RX_ACTIVE;
							bit_count <= 3'h0;
						end
					end
				end
				RX_ACTIVE: begin
					// R2 accept bits while enabled
					if (clk_rise) begin
						shift <= next_shift;
						bit_count <= bit_count + 3'h1;
					end
				end
				default: begin
					state <= RX_IDLE;
				end
			endcase
		end
	end

	// A new character beats a buffer read in the same cycle, so no done edge is lost.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_char_done <= 1'b0;
			rx_data_buffer <= 8'h00;
		end else begin
			if (char_load) begin
				rx_data_buffer <= next_shift;
			end
			// R4 enable fall clears done
			if (bus_init || enable_fell) begin
				rx_char_done <= 1'b0;
			end else if (char_load) begin
				rx_char_done <= 1'b1;
			end else if (rd_dbuf) begin
				rx_char_done <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Modem change flags
	// ************************************************************
	logic change_b;
	logic change_a;
	logic snap_b;
	logic snap_a;
	// R11 jumper inhibits change B
	wire chg_b_set = line_change & CHANGE_JUMPER_FITTED & ~CHANGE_ROUTE_TO_A;
	// R12 transitions routed to A
	wire chg_a_set = change_a_event | (line_change & CHANGE_ROUTE_TO_A);

	// The read clears only what prdata showed, so an event after the snapshot survives.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			change_b <= 1'b0;
			change_a <= 1'b0;
		end else if (bus_init) begin
			change_b <= 1'b0;
			change_a <= 1'b0;
		end else begin
			// R10 set on line transition
			// R13 cleared by register read
			change_b <= chg_b_set | (change_b & ~(rd_csr & snap_b));
			change_a <= chg_a_set | (change_a & ~(rd_csr & snap_a));
		end
	end

	// ************************************************************
	// Interrupts
	// ************************************************************
	rmcb_irq_t irq_status;
	wire [`RMCB_IRQ_W-1:0] irq_set = {char_load, chg_a_set, chg_b_set};
	wire [`RMCB_IRQ_W-1:0] irq_clr = (wr && sel_istat) ? pwdata[`RMCB_IRQ_W-1:0] : '0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= '0;
		end else begin
			irq_status <= irq_set | (irq_status & ~irq_clr);
		end
	end

	assign irq = |(irq_status & irq_mask);
	// R15 receiver vector request
	assign rx_vector_req = (chg_irq_en & change_a) | (rx_irq_en & rx_char_done);
	// ************************************************************
	// Read data
	// ************************************************************
	logic [15:0] csr_view;
	always_comb begin
		csr_view = 16'h0000;
		csr_view[`RMCB_BIT_CHG_B] = change_b;
		csr_view[`RMCB_BIT_DTR] = data_terminal_ready;
		csr_view[`RMCB_BIT_RTS] = request_to_send;
		csr_view[`RMCB_BIT_SEC_TX] = sec_tx_data;
		csr_view[`RMCB_BIT_RCV_EN] = receiver_enable;
		csr_view[`RMCB_BIT_CHG_IEN] = chg_irq_en;
		csr_view[`RMCB_BIT_RX_IEN] = rx_irq_en;
		csr_view[`RMCB_BIT_DONE] = rx_char_done;
		csr_view[`RMCB_BIT_ACTIVE] = rx_active;
		csr_view[`RMCB_BIT_CHG_A] = change_a;
	end
	wire [31:0] read_mux = sel_csr ? {16'h0000, csr_view} :
		sel_dbuf ? {24'h000000, rx_data_buffer} :
		sel_istat ? {29'h00000000, irq_status} :
		sel_imask ? {29'h00000000, irq_mask} :
		sel_sync ? {24'h000000, sync_pattern} : 32'h00000000;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			snap_b <= 1'b0;
			snap_a <= 1'b0;
		end else if (setup) begin
			prdata <= read_mux;
			snap_b <= change_b & sel_csr & ~pwrite;
			snap_a <= change_a & sel_csr & ~pwrite;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_hunt_start; receiver_enable && state == RX_IDLE |=> state == RX_HUNT || !receiver_enable; endproperty
	a_hunt_start: assert property (p_hunt_start) else $error("hunt did not start"); // R1
	property p_done_needs_enable; $rose(rx_char_done) |-> $past(receiver_enable) && $past(rx_active); endproperty
	a_done_needs_enable: assert property (p_done_needs_enable) else $error("done set while disabled"); // R2
	property p_disable_resets; !receiver_enable |=> state == RX_IDLE && bit_count == 3'h0; endproperty
	a_disable_resets: assert property (p_disable_resets) else $error("receiver not reset"); // R3
	property p_fall_clears_done; $fell(receiver_enable) |=> !rx_char_done; endproperty
	a_fall_clears_done: assert property (p_fall_clears_done) else $error("done survived disable"); // R4
	property p_init_clears_enable; bus_init |=> !receiver_enable && !chg_irq_en; endproperty
	a_init_clears_enable: assert property (p_init_clears_enable) else $error("init left enable"); // R5
	property p_sec_tx_write; wr_csr && !bus_init |=> sec_tx_data == $past(pwdata[`RMCB_BIT_SEC_TX]); endproperty
	a_sec_tx_write: assert property (p_sec_tx_write) else $error("sec tx not written"); // R6
	property p_rts_write;
		wr_csr && !bus_init |=> request_to_send == $past(pwdata[`RMCB_BIT_RTS]) && csr_view[2] == request_to_send;
	endproperty
	a_rts_write: assert property (p_rts_write) else $error("rts not written"); // R8
	property p_dtr_write; wr_csr && !bus_init |=> data_terminal_ready == $past(pwdata[`RMCB_BIT_DTR]); endproperty
	a_dtr_write: assert property (p_dtr_write) else $error("dtr not written"); // R9
	property p_change_b_set;
		line_change && CHANGE_JUMPER_FITTED && !CHANGE_ROUTE_TO_A && !bus_init |=> change_b;
	endproperty
	a_change_b_set: assert property (p_change_b_set) else $error("change b missed"); // R10
	property p_change_b_inhibit; !CHANGE_JUMPER_FITTED || CHANGE_ROUTE_TO_A |-> !change_b; endproperty
	a_change_b_inhibit: assert property (p_change_b_inhibit) else $error("change b set while inhibited"); // R11
	property p_route_to_a; CHANGE_ROUTE_TO_A && line_change && !bus_init |=> change_a; endproperty
	a_route_to_a: assert property (p_route_to_a) else $error("change a missed"); // R12
	property p_read_clears_b; rd_csr && snap_b && !chg_b_set && !bus_init |=> !change_b; endproperty
	a_read_clears_b: assert property (p_read_clears_b) else $error("read did not clear change b"); // R13
	property p_char_done; char_load && !bus_init |=> rx_char_done && rx_data_buffer == $past(next_shift); endproperty
	a_char_done: assert property (p_char_done) else $error("character not posted"); // R14
	property p_vector_req; change_a && chg_irq_en |-> rx_vector_req; endproperty
	a_vector_req: assert property (p_vector_req) else $error("vector request missing"); // R15

	c_sync_found: cover property (state == RX_HUNT ##1 state == RX_ACTIVE);
	c_char_done: cover property ($rose(rx_char_done));
	c_read_clear: cover property (change_b ##1 rd_csr ##1 !change_b);
	c_irq: cover property ($rose(irq));

endmodule : rmcb_receiver_control
`default_nettype wire

// ==== sim/rmcb_modem_model.sv ====
// Modem model: receive clock, serial data and the three status leads.
// Assumes the bench calls its tasks; the clock stands still between frames.
`timescale 1ns/10ps
`default_nettype none
module rmcb_modem_model (
	output logic modem_clock, // receive clock
	output logic modem_rx_data, // serial data
	output logic carrier, // carrier lead
	output logic data_set_ready, // data set ready lead
	output logic sec_rx_data // secondary data lead
);
	initial begin
		modem_clock = 1'b0;
		modem_rx_data = 1'b0;
		carrier = 1'b0;
		data_set_ready = 1'b0;
		sec_rx_data = 1'b0;
	end
	// Data moves while the clock is low, so each rise finds it settled.
	task send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			modem_rx_data = b[i];
			#100 modem_clock = ~modem_clock;
			#100 modem_clock = ~modem_clock;
		end
		modem_rx_data = ~b[0];
	endtask : send_byte
	task flip(input int which);
		case (which)
			0: carrier = ~carrier;
			1: data_set_ready = ~data_set_ready;
			default: sec_rx_data = ~sec_rx_data;
		endcase
	endtask : flip
endmodule : rmcb_modem_model
`default_nettype wire

// ==== sim/receiver_modem_control_bits_bench.sv ====
// Self-checking bench for the receiver control bits over APB.
// Assumes the design package, its header and the modem model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "rmcb_cfg.svh"
module receiver_modem_control_bits_bench;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, bus_init, change_a_event, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, q;
	logic [31:0] prdata;
	logic pready, pslverr, sec_tx_data, request_to_send, data_terminal_ready, rx_vector_req, irq;
	logic modem_clock, modem_rx_data, carrier, data_set_ready, sec_rx_data;
	wire logic [31:0] leads;
	int err_total = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [15:0] row_wr [6];
	logic [15:0] row_rd [6];
	logic [2:0] row_leads [6];
	assign leads = {29'h0, sec_tx_data, request_to_send, data_terminal_ready};
	always #12.5 pclk = ~pclk;
	rmcb_receiver_control rmcb_receiver_control_inst (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .bus_init, .change_a_event, .modem_clock, .modem_rx_data,
		.carrier, .data_set_ready, .sec_rx_data, .sec_tx_data, .request_to_send, .data_terminal_ready,
		.rx_vector_req, .irq);
	rmcb_modem_model rmcb_modem_model_inst (.modem_clock, .modem_rx_data, .carrier, .data_set_ready,
		.sec_rx_data);
	// ****************
	// Shared tasks
	// ****************
	task chk32(input string n, input logic [31:0] x, input logic [31:0] g);
		samples_checked++;
		if (g !== x) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, g);
		end
	endtask : chk32
	task chk1(input string n, input logic x, input logic g);
		samples_checked++;
		if (g !== x) begin
			err_total++;
			$display("CHECK FAILED %s expected %b seen %b", n, x, g);
		end
	endtask : chk1
	// One extra edge at the end lets the transfer's effects land before any check.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		if (n >= 50) err_total++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task tick(input int k);
		repeat (k) @(posedge pclk);
	endtask : tick
	task wrap_up;
		$display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 10000) begin
			err_total++;
			wrap_up();
		end
	end
	// ****************
	// Main sequence
	// ****************
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		bus_init = 1'b0;
		change_a_event = 1'b0;
		row_wr = '{16'h000e, 16'h0002, 16'h0004, 16'h0008, 16'h8881, 16'h0060};
		row_rd = '{16'h000e, 16'h0002, 16'h0004, 16'h0008, 16'h0000, 16'h0060};
		row_leads = '{3'h7, 3'h1, 3'h2, 3'h4, 3'h0, 3'h0};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `RMCB_OFF_CSR, 32'h0);
		chk32("csr", 32'h0, q);
		apb(1'b0, `RMCB_OFF_ISTAT, 32'h0);
		chk32("istat", 32'h0, q);
		apb(1'b0, `RMCB_OFF_SYNC, 32'h0);
		chk32("sync", 32'h96, q);
		chk32("leads", 32'h0, leads);
		apb(1'b0, 12'h014, 32'h0);
		chk32("unmapped", 32'h0, q);
		chk1("pslverr", 1'b1, e);
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, `RMCB_OFF_CSR, {16'h0, row_wr[i]});
			apb(1'b0, `RMCB_OFF_CSR, 32'h0);
			chk32("csr", {16'h0, row_rd[i]}, q);
			chk32("leads", {29'h0, row_leads[i]}, leads);
		end
		apb(1'b1, `RMCB_OFF_CSR, 32'h0);
		apb(1'b1, `RMCB_OFF_IMASK, 32'h1);
		for (int i = 0; i < 6; i++) begin
			rmcb_modem_model_inst.flip(i % 3);
			tick(8);
			chk1("irq", 1'b1, irq);
			apb(1'b0, `RMCB_OFF_CSR, 32'h0);
			chk1("change_b", 1'b1, q[0]);
			apb(1'b0, `RMCB_OFF_CSR, 32'h0);
			chk1("change_b", 1'b0, q[0]);
			apb(1'b1, `RMCB_OFF_ISTAT, 32'h1);
			chk1("irq", 1'b0, irq);
		end
		apb(1'b1, `RMCB_OFF_IMASK, 32'h0);
		rmcb_modem_model_inst.flip(0);
		tick(8);
		chk1("irq", 1'b0, irq);
		apb(1'b1, `RMCB_OFF_CSR, 32'h20);
		change_a_event <= 1'b1;
		@(posedge pclk);
		change_a_event <= 1'b0;
		tick(2);
		chk1("vector", 1'b1, rx_vector_req);
		apb(1'b0, `RMCB_OFF_CSR, 32'h0);
		chk1("change_a", 1'b1, q[15]);
		chk1("vector", 1'b0, rx_vector_req);
		apb(1'b1, `RMCB_OFF_CSR, 32'h10);
		apb(1'b0, `RMCB_OFF_CSR, 32'h0);
		chk32("csr", 32'h10, q);
		rmcb_modem_model_inst.send_byte(8'h96);
		rmcb_modem_model_inst.send_byte(8'ha5);
		tick(8);
		apb(1'b0, `RMCB_OFF_CSR, 32'h0);
		chk32("csr", 32'h890, q);
		apb(1'b0, `RMCB_OFF_DBUF, 32'h0);
		chk32("dbuf", 32'ha5, q);
		apb(1'b0, `RMCB_OFF_CSR, 32'h0);
		chk32("csr", 32'h810, q);
		rmcb_modem_model_inst.send_byte(8'h3c);
		tick(8);
		apb(1'b0, `RMCB_OFF_CSR, 32'h0);
		chk32("csr", 32'h890, q);
		apb(1'b1, `RMCB_OFF_CSR, 32'h0);
		apb(1'b0, `RMCB_OFF_CSR, 32'h0);
		chk32("csr", 32'h0, q);
		rmcb_modem_model_inst.send_byte(8'h96);
		rmcb_modem_model_inst.send_byte(8'h11);
		tick(8);
		apb(1'b0, `RMCB_OFF_CSR, 32'h0);
		chk32("csr", 32'h0, q);
		apb(1'b0, `RMCB_OFF_DBUF, 32'h0);
		chk32("dbuf", 32'h3c, q);
		apb(1'b1, `RMCB_OFF_CSR, 32'h7e);
		bus_init <= 1'b1;
		@(posedge pclk);
		bus_init <= 1'b0;
		tick(1);
		chk32("leads", 32'h0, leads);
		apb(1'b0, `RMCB_OFF_CSR, 32'h0);
		chk32("csr", 32'h0, q);
		// Mid-run reset with the carrier lead still high must not post a change.
		apb(1'b1, `RMCB_OFF_SYNC, 32'h5a);
		apb(1'b1, `RMCB_OFF_CSR, 32'h1e);
		presetn <= 1'b0;
		tick(2);
		presetn <= 1'b1;
		chk32("leads", 32'h0, leads);
		tick(8);
		apb(1'b0, `RMCB_OFF_CSR, 32'h0);
		chk32("csr", 32'h0, q);
		apb(1'b0, `RMCB_OFF_SYNC, 32'h0);
		chk32("sync", 32'h96, q);
		apb(1'b0, `RMCB_OFF_ISTAT, 32'h0);
		chk32("istat", 32'h0, q);
		wrap_up();
	end
endmodule : receiver_modem_control_bits_bench
`default_nettype wire
